//--- hw/dsr_byte_mux.sv
`timescale 1ns/100ps
`include "dsr_map.svh"
// Builds the answer byte for a read-back command, registered
module dsr_byte_mux
    import dsr_pkg::*;
(
    // Clock and reset
    input  wire logic       i_core_clk,
    input  wire logic       i_rstn,
    // Selection
    input  wire logic       i_load,
    input  wire logic [7:0] i_cmd,
    input  wire dsr_mode_t  i_mode,
    // Answer
    output logic      [7:0] o_byte,
    output logic            o_hit
);
    logic [7:0] orient_byte;
    logic [7:0] pixfmt_byte;
    logic [7:0] image_byte;
    logic [7:0] signal_byte;
    logic [7:0] sel_byte;
    logic       sel_hit;

    // Orientation: flags high, D2..D0 zero
    assign orient_byte = {i_mode.row_addr_order_flag,
                          i_mode.col_addr_order_flag,
                          i_mode.axis_swap_flag,
                          i_mode.refresh_order_flag,
                          i_mode.bgr_order_flag, 3'b000};
    // Pixel formats; D3 is unused and reads zero
    assign pixfmt_byte = {i_mode.rgb_port_color_format, 1'b0,
                          i_mode.host_port_color_format};
    // Image mode: D6, D4, D3 zero
    assign image_byte  = {i_mode.scroll_active_flag, 1'b0,
                          i_mode.inversion_active_flag, 2'b00,
                          i_mode.gamma_curve_select};
    // Signal mode: D1, D0 zero
    assign signal_byte = {i_mode.tear_output_enable,
                          i_mode.tear_output_kind,
                          i_mode.hsync_active_flag,
                          i_mode.vsync_active_flag,
                          i_mode.pixclk_active_flag,
                          i_mode.data_enable_active_flag, 2'b00};

    // Command decode
    always_comb begin
        sel_hit  = 1'b1;
        sel_byte = 8'h00;
        unique case (i_cmd)
            `DSR_CMD_ORIENT: sel_byte = orient_byte;
            `DSR_CMD_PIXFMT: sel_byte = pixfmt_byte;
            `DSR_CMD_IMAGE:  sel_byte = image_byte;
            `DSR_CMD_SIGNAL: sel_byte = signal_byte;
            default:         sel_hit  = 1'b0;
        endcase
    end

    // Capture at command time so a read sees a stable byte
    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_byte <= 8'h00;
            o_hit  <= 1'b0;
        end else if (i_load) begin
            o_byte <= sel_byte;
            o_hit  <= sel_hit;
        end
    end
endmodule : dsr_byte_mux

//--- hw/dsr_readback.sv
`timescale 1ns/100ps
`include "dsr_map.svh"
//----------------------------------------------------------------------
// Operation
// - Command 0Bh: dummy, then orientation byte.
// - Orientation: row D7, column D6, swap D5, refresh D4, BGR D3.
// - Address order 1 decrement; swap 1 exchanged; colour 1 BGR.
// - Refresh order 1 top to bottom, 0 bottom to top.
// - Command 0Ch: dummy, RGB format D7:D4, host D2:D0, default 66h.
// - Host format 011/101/110 = 12/16/18 bpp, 111 reserved.
// - RGB format 0101/0110/1110, 0111 reserved.
// - Command 0Dh: dummy, scroll D7, inversion D5, gamma D2:D0.
// - Gamma codes 000..011 curves 0..3; higher undefined.
// - Scroll and inversion flags high only while active.
// - Command 0Eh: dummy, tear D7:D6, hsync, vsync, pixclk, enable.
// - RGB signal flags 1 when active, 0 when off.
// - Signal mode byte reads 00h after every reset.
// - Parallel needs dummy read; serial shifts byte right after command.
// - Command written low select on write rise; reads on read rise.
//----------------------------------------------------------------------
module dsr_readback
    import dsr_pkg::*;
(
    // Clock and reset
    input  wire logic       i_core_clk,
    input  wire logic       i_rstn,
    // Mode state from the write-command logic
    input  wire dsr_mode_t  i_mode,
    // Parallel host port
    input  wire logic       i_command_data_select,
    input  wire logic       i_write_strobe_n,
    input  wire logic       i_read_strobe_n,
    input  wire logic [17:0] i_data,
    output logic     [7:0]  o_data,
    output logic            o_data_oe,
    // Serial host port
    input  wire logic       i_ser_cs_n,
    input  wire logic       i_ser_sclk,
    input  wire logic       i_ser_sdi,
    output logic            o_ser_sdo,
    output logic            o_ser_sdo_oe
);
    //------------------------------------------------------------------
    // Pin synchronisers
    //------------------------------------------------------------------
    dsr_par_t   par_raw;
    dsr_par_t   par_s;
    logic [2:0] ser_s;

    // Only D7..D0 enter the core; D17..D8 never reach logic
    assign par_raw = '{command_data_select: i_command_data_select,
                       write_strobe_n:      i_write_strobe_n,
                       read_strobe_n:       i_read_strobe_n,
                       data:                i_data[7:0]};

    dsr_sync #(.WIDTH($bits(dsr_par_t))) u_par_sync (
        .i_core_clk (i_core_clk),
        .i_rstn     (i_rstn),
        .i_async    (par_raw),
        .i_rst_val  ('1),
        .o_sync     (par_s)
    );

    dsr_sync #(.WIDTH(3)) u_ser_sync (
        .i_core_clk (i_core_clk),
        .i_rstn     (i_rstn),
        .i_async    ({i_ser_cs_n, i_ser_sclk, i_ser_sdi}),
        .i_rst_val  ('1),
        .o_sync     (ser_s)
    );

    //------------------------------------------------------------------
    // Edge detection
    //------------------------------------------------------------------
    logic wr_d_reg;
    logic rd_d_reg;
    logic sclk_d_reg;
    logic wr_rise;
    logic rd_rise;
    logic sclk_rise;
    logic sclk_fall;
    logic cs_active;

    // Delayed copies of synchronised strobes
    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            wr_d_reg   <= 1'b1;
            rd_d_reg   <= 1'b1;
            sclk_d_reg <= 1'b1;
        end else begin
            wr_d_reg   <= par_s.write_strobe_n;
            rd_d_reg   <= par_s.read_strobe_n;
            sclk_d_reg <= ser_s[1];
        end
    end

    assign wr_rise   = par_s.write_strobe_n & ~wr_d_reg;
    assign rd_rise   = par_s.read_strobe_n & ~rd_d_reg;
    assign sclk_rise = ser_s[1] & ~sclk_d_reg;
    assign sclk_fall = ~ser_s[1] & sclk_d_reg;
    assign cs_active = ~ser_s[2];

    //------------------------------------------------------------------
    // Parallel command decode and read sequence
    //------------------------------------------------------------------
    dsr_state_t state_reg;
    dsr_state_t state_next;
    logic       par_cmd_take;
    logic       par_rd_take;
    logic       ser_cmd_take;
    logic [7:0] ser_cmd_reg;
    logic       cmd_load;
    logic [7:0] cmd_code;
    logic [7:0] ans_byte;
    logic       ans_hit;

    // Command on write rise with select low; write must idle for reads
    assign par_cmd_take = wr_rise & ~par_s.command_data_select;
    assign par_rd_take  = rd_rise & par_s.command_data_select
                          & par_s.write_strobe_n;
    assign cmd_load     = par_cmd_take | ser_cmd_take;
    // Serial code includes the eighth bit arriving on this very edge
    assign cmd_code     = par_cmd_take ? par_s.data
                          : {ser_cmd_reg[6:0], ser_s[0]};

    dsr_byte_mux u_mux (
        .i_core_clk (i_core_clk),
        .i_rstn     (i_rstn),
        .i_load     (cmd_load),
        .i_cmd      (cmd_code),
        .i_mode     (i_mode),
        .o_byte     (ans_byte),
        .o_hit      (ans_hit)
    );

    // A fresh command always restarts the sequence
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            DSR_IDLE:  state_next = DSR_IDLE;
            DSR_DUMMY: if (par_rd_take) state_next = DSR_DATA;
            DSR_DATA:  if (par_rd_take) state_next = DSR_IDLE;
        endcase
        if (par_cmd_take) begin
            state_next = DSR_DUMMY;
        end
    end

    // Unknown codes skip to idle on the following cycle
    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            state_reg <= DSR_IDLE;
        end else if (state_reg == DSR_DUMMY && !ans_hit && !par_cmd_take
                     && wr_d_reg) begin
            state_reg <= DSR_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // Drive the bus while the host reads in the data phase
    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_data    <= `DSR_SIGNAL_RST;
            o_data_oe <= 1'b0;
        end else begin
            o_data    <= (state_reg == DSR_DATA) ? ans_byte : 8'h00;
            o_data_oe <= (state_reg == DSR_DATA) & ans_hit
                         & ~par_s.read_strobe_n;
        end
    end

    //------------------------------------------------------------------
    // Serial link: 8-bit command in, 8-bit answer out, no dummy
    //------------------------------------------------------------------
    logic [3:0] ser_cnt_reg;
    logic [7:0] ser_sh_reg;
    logic       ser_out_reg;
    logic       ser_loaded_reg;

    assign ser_cmd_take = cs_active & sclk_rise
                          & (ser_cnt_reg == 4'(`DSR_SER_BITS - 1))
                          & ~ser_out_reg;

    // Shift command in on rise; answer leaves on falls
    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            ser_cmd_reg    <= 8'h00;
            ser_cnt_reg    <= 4'h0;
            ser_out_reg    <= 1'b0;
            ser_loaded_reg <= 1'b0;
            ser_sh_reg     <= 8'h00;
        end else if (!cs_active) begin
            ser_cnt_reg    <= 4'h0;
            ser_out_reg    <= 1'b0;
            ser_loaded_reg <= 1'b0;
        end else if (!ser_out_reg) begin
            if (sclk_rise) begin
                ser_cmd_reg <= {ser_cmd_reg[6:0], ser_s[0]};
                ser_cnt_reg <= ser_cnt_reg + 4'h1;
            end
            if (ser_cmd_take) begin
                ser_out_reg <= 1'b1;
                ser_cnt_reg <= 4'h0;
            end
        end else begin
            if (!ser_loaded_reg) begin
                ser_sh_reg     <= ans_byte;
                ser_loaded_reg <= 1'b1;
            end else if (sclk_fall) begin
                // First fall presents D7; later falls advance
                if (ser_cnt_reg != 4'h0) begin
                    ser_sh_reg <= {ser_sh_reg[6:0], 1'b0};
                end
                ser_cnt_reg <= ser_cnt_reg + 4'h1;
            end
        end
    end

    // Output bit registered straight from shifter head
    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_ser_sdo    <= 1'b0;
            o_ser_sdo_oe <= 1'b0;
        end else begin
            o_ser_sdo    <= ser_sh_reg[7];
            o_ser_sdo_oe <= ser_out_reg & ser_loaded_reg & ans_hit
                            & cs_active
                            & (ser_cnt_reg <= 4'(`DSR_SER_BITS));
        end
    end

    //------------------------------------------------------------------
    // Assertions
    //------------------------------------------------------------------
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_rstn);

    cmd_restart_a: assert property (par_cmd_take
                                   |=> state_reg == DSR_DUMMY)
        else $error("command write did not restart sequence");
    dummy_silent_a: assert property (state_reg == DSR_DUMMY
                                     |=> !o_data_oe)
        else $error("bus driven during dummy read");
    dummy_then_data_a: assert property (state_reg == DSR_DUMMY && par_rd_take
                                        && !par_cmd_take
                                        |=> state_reg == DSR_DATA)
        else $error("dummy read did not advance");
    data_done_a: assert property (state_reg == DSR_DATA && par_rd_take
                                  && !par_cmd_take |=> state_reg == DSR_IDLE)
        else $error("data read did not finish");
    orient_low_a: assert property (cmd_load && cmd_code == `DSR_CMD_ORIENT
                                   |=> ans_byte[2:0] == 3'b000)
        else $error("orientation low bits not zero");
    pixfmt_d3_a: assert property (cmd_load && cmd_code == `DSR_CMD_PIXFMT
                                  |=> ans_byte[3] == 1'b0)
        else $error("pixel format D3 not zero");
    image_zero_a: assert property (cmd_load && cmd_code == `DSR_CMD_IMAGE
                                   |=> ans_byte[6] == 1'b0
                                       && ans_byte[4:3] == 2'b00)
        else $error("image mode reserved bits not zero");
    signal_map_a: assert property (cmd_load && cmd_code == `DSR_CMD_SIGNAL
                                   |=> ans_byte[7] ==
                                       $past(i_mode.tear_output_enable)
                                       && ans_byte[1:0] == 2'b00)
        else $error("signal mode byte wrong");
    read_gate_a: assert property (o_data_oe |-> $past(state_reg)
                                  == DSR_DATA)
        else $error("bus driven outside data phase");

    data_read_c: cover property (state_reg == DSR_DATA ##1 o_data_oe);
    abandon_c: cover property (state_reg == DSR_DATA && par_cmd_take);
    serial_c: cover property (ser_cmd_take ##[1:200] o_ser_sdo_oe);
endmodule : dsr_readback

//--- hw/dsr_sync.sv
`timescale 1ns/100ps
// Two-flop synchroniser for a vector of pin inputs
module dsr_sync #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input  wire logic             i_core_clk,
    input  wire logic             i_rstn,
    // Data
    input  wire logic [WIDTH-1:0] i_async,
    input  wire logic [WIDTH-1:0] i_rst_val,
    output logic      [WIDTH-1:0] o_sync
);
    logic [WIDTH-1:0] meta_reg;

    // First stage is read only by the second
    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            meta_reg <= '1;
            o_sync   <= '1;
        end else begin
            meta_reg <= i_async;
            o_sync   <= meta_reg;
        end
    end
endmodule : dsr_sync

//--- pkg/dsr_map.svh
`ifndef DSR_MAP_SVH
`define DSR_MAP_SVH
// Command codes
`define DSR_CMD_ORIENT      8'h0b
`define DSR_CMD_PIXFMT      8'h0c
`define DSR_CMD_IMAGE       8'h0d
`define DSR_CMD_SIGNAL      8'h0e
// Reset values of the read-back bytes
`define DSR_ORIENT_RST      8'h00
`define DSR_PIXFMT_RST      8'h66
`define DSR_IMAGE_RST       8'h00
`define DSR_SIGNAL_RST      8'h00
// Field positions, orientation byte
`define DSR_OR_ROW_BIT      7
`define DSR_OR_COL_BIT      6
`define DSR_OR_SWAP_BIT     5
`define DSR_OR_REFR_BIT     4
`define DSR_OR_BGR_BIT      3
// Field positions, pixel format byte
`define DSR_PF_RGB_LSB      4
`define DSR_PF_HOST_LSB     0
// Field positions, image mode byte
`define DSR_IM_SCROLL_BIT   7
`define DSR_IM_INV_BIT      5
`define DSR_IM_GAMMA_LSB    0
// Field positions, signal mode byte
`define DSR_SM_TEAR_OUTPUT_ENABLE_BIT     7
`define DSR_SM_TEKIND_BIT   6
`define DSR_SM_HS_BIT       5
`define DSR_SM_VS_BIT       4
`define DSR_SM_PCK_BIT      3
`define DSR_SM_DE_BIT       2
// Serial shift length
`define DSR_SER_BITS        8
`endif

//--- pkg/dsr_pkg.sv
package dsr_pkg;
    // Mode state gathered from write commands
    typedef struct packed {
        logic       row_addr_order_flag;
        logic       col_addr_order_flag;
        logic       axis_swap_flag;
        logic       refresh_order_flag;
        logic       bgr_order_flag;
        logic [3:0] rgb_port_color_format;
        logic [2:0] host_port_color_format;
        logic       scroll_active_flag;
        logic       inversion_active_flag;
        logic [2:0] gamma_curve_select;
        logic       tear_output_enable;
        logic       tear_output_kind;
        logic       hsync_active_flag;
        logic       vsync_active_flag;
        logic       pixclk_active_flag;
        logic       data_enable_active_flag;
    } dsr_mode_t;

    // Parallel host pins after synchronisation
    typedef struct packed {
        logic       command_data_select;
        logic       write_strobe_n;
        logic       read_strobe_n;
        logic [7:0] data;
    } dsr_par_t;

    typedef enum logic [2:0] {
        DSR_IDLE  = 3'b001,
        DSR_DUMMY = 3'b010,
        DSR_DATA  = 3'b100
    } dsr_state_t;
endpackage : dsr_pkg

//--- test/dsr_host_model.sv
`timescale 1ns/100ps
// Host controller on the parallel and serial ports of the read-back block
module dsr_host_model
    import dsr_pkg::*;
(
    // Clock
    input  wire logic        i_core_clk,
    // Answer pins from the device
    input  wire logic [7:0]  i_bus,
    input  wire logic        i_bus_oe,
    input  wire logic        i_sdo,
    // Parallel pins
    output logic             o_sel,
    output logic             o_wr_n,
    output logic             o_rd_n,
    output logic [17:0]      o_data,
    // Serial pins
    output logic             o_cs_n,
    output logic             o_sclk,
    output logic             o_sdi
);
    localparam int PHASE = 6;
    logic [17:0] junk;
    logic        drive;
    logic [7:0]  wbyte;

    // Idle pins; the serial clock stands still low outside frames
    initial begin
        junk = 18'h00000;
        drive = 1'b0;
        wbyte = 8'h00;
        o_sel = 1'b1;
        o_wr_n = 1'b1;
        o_rd_n = 1'b1;
        o_cs_n = 1'b1;
        o_sclk = 1'b0;
        o_sdi = 1'b0;
    end

    // Undriven lines wander every cycle so a stale value never matches
    always @(negedge i_core_clk) begin
        junk <= junk + 18'h2d5a3;
    end
    assign o_data = {junk[17:8],
                     drive ? wbyte : (i_bus_oe ? i_bus : junk[7:0])};

    task automatic wait_clk(input int n);
        repeat (n) @(negedge i_core_clk);
    endtask : wait_clk

    // Command byte with select low, latched by the rising write strobe
    task automatic par_cmd(input logic [7:0] cmd);
        wait_clk(1);
        o_sel = 1'b0;
        wbyte = cmd;
        drive = 1'b1;
        o_wr_n = 1'b0;
        wait_clk(PHASE);
        o_wr_n = 1'b1;
        wait_clk(PHASE);
        drive = 1'b0;
        o_sel = 1'b1;
    endtask : par_cmd

    // One parameter read; held low until the device drives, bounded
    task automatic par_read(output logic [7:0] val, output logic oe);
        int n;
        wait_clk(1);
        o_rd_n = 1'b0;
        n = 0;
        while (i_bus_oe !== 1'b1 && n < 12) begin
            wait_clk(1);
            n++;
        end
        wait_clk(1);
        val = i_bus;
        oe = i_bus_oe;
        o_rd_n = 1'b1;
        wait_clk(PHASE);
    endtask : par_read

    // Serial frame: command MSB first, answer straight after, no dummy
    task automatic ser_read(input logic [7:0] cmd, output logic [7:0] val);
        o_cs_n = 1'b0;
        wait_clk(PHASE);
        for (int i = 7; i >= 0; i--) begin
            o_sclk = 1'b0;
            o_sdi = cmd[i];
            wait_clk(PHASE);
            o_sclk = 1'b1;
            wait_clk(PHASE);
        end
        for (int i = 7; i >= 0; i--) begin
            o_sclk = 1'b0;
            o_sdi = ~o_sdi;
            wait_clk(PHASE);
            val[i] = i_sdo;
            o_sclk = 1'b1;
            wait_clk(PHASE);
        end
        o_sclk = 1'b0;
        wait_clk(PHASE);
        o_cs_n = 1'b1;
        o_sdi = ~o_sdi;
        wait_clk(PHASE);
    endtask : ser_read
endmodule : dsr_host_model

//--- test/test_display_status_readback.sv
`timescale 1ns/100ps
module test_display_status_readback
    import dsr_pkg::*;
;
    logic        i_core_clk;
    logic        i_rstn;
    dsr_mode_t   mode;
    logic [17:0] pins;
    logic [7:0]  o_data;
    logic        o_data_oe, sel, wr_n, rd_n, cs_n, sclk, sdi, sdo, sdo_oe;
    logic [$bits(dsr_mode_t)-1:0] raw;
    logic [31:0] seed;
    logic [7:0]  seen;
    logic        oe;
    int          mismatches, n_tests;
    int          exp_q[$];
    logic [7:0]  rst_tab [4] = '{8'h00, 8'h66, 8'h00, 8'h00};
    logic [2:0]  host_codes [4] = '{3'h3, 3'h5, 3'h6, 3'h7};
    logic [3:0]  rgb_codes [4] = '{4'h5, 4'h6, 4'h7, 4'he};

    dsr_readback u_dut (
        .i_core_clk(i_core_clk), .i_rstn(i_rstn), .i_mode(mode),
        .i_command_data_select(sel), .i_write_strobe_n(wr_n),
        .i_read_strobe_n(rd_n), .i_data(pins), .o_data(o_data),
        .o_data_oe(o_data_oe), .i_ser_cs_n(cs_n), .i_ser_sclk(sclk),
        .i_ser_sdi(sdi), .o_ser_sdo(sdo), .o_ser_sdo_oe(sdo_oe));
    dsr_host_model u_host (
        .i_core_clk(i_core_clk), .i_bus(o_data), .i_bus_oe(o_data_oe),
        .i_sdo(sdo), .o_sel(sel), .o_wr_n(wr_n), .o_rd_n(rd_n),
        .o_data(pins), .o_cs_n(cs_n), .o_sclk(sclk), .o_sdi(sdi));

    // 20 MHz core clock
    initial begin
        i_core_clk = 1'b0;
        forever #25 i_core_clk = ~i_core_clk;
    end

    //------------------------------------------------------------------
    // Reference model and helpers
    //------------------------------------------------------------------
    function automatic logic [31:0] xorshift(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction : xorshift

    // Expected answer byte; -1 marks a command with no answer
    function automatic int model_byte(input logic [7:0] c, dsr_mode_t m);
        case (c)
            8'h0b: return 128 * m.row_addr_order_flag
                   + 64 * m.col_addr_order_flag + 32 * m.axis_swap_flag
                   + 16 * m.refresh_order_flag + 8 * m.bgr_order_flag;
            8'h0c: return 16 * m.rgb_port_color_format
                   + m.host_port_color_format;
            8'h0d: return 128 * m.scroll_active_flag
                   + 32 * m.inversion_active_flag + m.gamma_curve_select;
            8'h0e: return 128 * m.tear_output_enable
                   + 64 * m.tear_output_kind + 32 * m.hsync_active_flag
                   + 16 * m.vsync_active_flag + 8 * m.pixclk_active_flag
                   + 4 * m.data_enable_active_flag;
            default: return -1;
        endcase
    endfunction : model_byte

    task automatic conclude();
        $display("comparisons %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : conclude

    task automatic check(input string what, logic [7:0] got, logic [7:0] ex);
        n_tests++;
        if (got !== ex) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", what, ex, got);
        end
    endtask : check

    // Mode reset values: RGB and host formats both 110
    task automatic mode_default();
        mode = '0;
        mode.rgb_port_color_format = 4'h6;
        mode.host_port_color_format = 3'h6;
    endtask : mode_default

    // Command, dummy read, data read; a missing answer ends the run
    task automatic par_seq(input logic [7:0] cmd);
        exp_q.push_back(model_byte(cmd, mode));
        u_host.par_cmd(cmd);
        u_host.par_read(seen, oe);
        u_host.par_read(seen, oe);
        check("answer drive", {7'h00, oe}, 8'h01);
        check("answer byte", seen, 8'(exp_q.pop_front()));
        if (oe !== 1'b1) conclude();
    endtask : par_seq

    task automatic idle_read();
        u_host.par_read(seen, oe);
        check("idle drive", {7'h00, oe}, 8'h00);
    endtask : idle_read

    //------------------------------------------------------------------
    // Main sequence
    //------------------------------------------------------------------
    initial begin
        mismatches = 0;
        n_tests = 0;
        seed = 32'h356a;
        i_rstn = 1'b0;
        mode_default();
        repeat (8) @(negedge i_core_clk);
        i_rstn = 1'b1;
        // Every read-back byte at its reset value
        for (int i = 0; i < 4; i++) begin
            par_seq(8'h0b + 8'(i));
            check("reset byte", seen, rst_tab[i]);
        end
        $display("test reset_values done");
        // Walking one through every mode flag on all four commands
        for (int b = 0; b < $bits(dsr_mode_t); b++) begin
            raw = '0;
            raw[b] = 1'b1;
            mode = raw;
            for (int c = 0; c < 4; c++) par_seq(8'h0b + 8'(c));
        end
        $display("test field_positions done");
        // Every listed format and gamma code
        for (int i = 0; i < 4; i++) begin
            mode_default();
            mode.host_port_color_format = host_codes[i];
            mode.rgb_port_color_format = rgb_codes[i];
            mode.gamma_curve_select = 3'(i);
            par_seq(8'h0c);
            par_seq(8'h0d);
        end
        $display("test code_tables done");
        // Serial reads with random mode, byte right after the command
        for (int i = 0; i < 8; i++) begin
            seed = xorshift(seed);
            raw = seed[$bits(dsr_mode_t)-1:0];
            mode = raw;
            exp_q.push_back(model_byte(8'h0b + 8'(i % 4), mode));
            u_host.ser_read(8'h0b + 8'(i % 4), seen);
            check("serial byte", seen, 8'(exp_q.pop_front()));
            check("serial release", {7'h00, sdo_oe}, 8'h00);
        end
        $display("test serial_reads done");
        // Unknown code refused, then a read cut short by a new command
        u_host.par_cmd(8'h09);
        idle_read();
        u_host.par_cmd(8'h0b);
        u_host.par_read(seen, oe);
        seed = xorshift(seed);
        raw = seed[$bits(dsr_mode_t)-1:0];
        mode = raw;
        par_seq(8'h0e);
        idle_read();
        $display("test abort_and_refuse done");
        // Reset in mid-sequence clears the state and the signal byte
        u_host.par_cmd(8'h0e);
        i_rstn = 1'b0;
        mode_default();
        repeat (4) @(negedge i_core_clk);
        i_rstn = 1'b1;
        idle_read();
        par_seq(8'h0e);
        check("signal after reset", seen, 8'h00);
        $display("test mid_reset done");
        conclude();
    end
endmodule : test_display_status_readback
